// File: hw/qtc_chan.sv
`timescale 1ns/100ps
module qtc_chan (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // timing strobes
   input wire logic cap_tick,
   input wire logic ref_tick,
   // captured host character
   input wire logic [1:0] tx_char_control,
   input wire logic [7:0] tx_char_byte,
   input wire logic tx_odd_parity_in,
   input wire logic special_char_select,
   // configuration
   input wire logic [1:0] tx_encode_mode,
   input wire logic [1:0] parity_check_control,
   input wire logic rx_common,
   input wire logic bist_en,
   input wire logic pa_enable,
   input wire logic realign_clear,
   input wire logic pa_fault_event,
   // results
   output logic err_out,
   output logic char_valid,
   output logic [2:0] char_kind,
   output logic [9:0] char_bits,
   output logic par_event,
   output logic fault_event,
   output logic bist_event
);

   typedef struct packed {
      logic err;
      logic valid;
      logic [2:0] kind;
      logic [9:0] bits;
      logic par_pend;
      logic par_evt;
      logic fault;
      logic fault_evt;
      logic [9:0] bist_cnt;
      logic [4:0] pulse_cnt;
      logic bist_evt;
   } qtc_chan_s;

   qtc_chan_s st_q, st_d;

   logic enc_on;
   logic incl_ctl;
   logic par_bad;
   logic with_sync;
   logic wrap;
   logic fault_set;
   logic fault_clr;
   logic [9:0] last_cnt;
   logic [4:0] width;

   always_comb begin
      st_d = st_q;
      st_d.valid = 1'b0;
      st_d.par_evt = 1'b0;
      st_d.fault_evt = 1'b0;
      st_d.bist_evt = 1'b0;
      enc_on = tx_encode_mode != qtc_pkg::QTC_SEL_LOW;
      // bypassed characters are ten bits, so control joins the check
      incl_ctl = (parity_check_control == qtc_pkg::QTC_SEL_HIGH) || !enc_on;
      par_bad = (parity_check_control != qtc_pkg::QTC_SEL_LOW) && cap_tick &&
         !(^tx_char_byte ^ tx_odd_parity_in ^ (incl_ctl & ^tx_char_control));
      // ----------------------------------------------------------------
      // capture and classification
      // ----------------------------------------------------------------
      if (cap_tick) begin
         st_d.valid = 1'b1;
         if (par_bad) begin
            st_d.kind = qtc_pkg::QTC_KIND_SPECIAL;
            st_d.bits = {2'b00, qtc_pkg::C07_BYTE};
         end else if (!enc_on) begin
            st_d.kind = qtc_pkg::QTC_KIND_RAW;
            st_d.bits = {tx_char_control, tx_char_byte};
         end else begin
            st_d.bits = {2'b00, tx_char_byte};
            case (tx_char_control)
               2'b00: st_d.kind = qtc_pkg::QTC_KIND_DATA;
               2'b01: st_d.kind = qtc_pkg::QTC_KIND_SPECIAL;
               2'b10: st_d.kind = qtc_pkg::QTC_KIND_FILL;
               2'b11: begin
                  // select only steers in the mode that uses it
                  if (tx_encode_mode != qtc_pkg::QTC_SEL_MID || special_char_select) begin
                     st_d.kind = qtc_pkg::QTC_KIND_SYNC;
                  end else begin
                     st_d.kind = qtc_pkg::QTC_KIND_SPECIAL;
                  end
               end
               default: st_d.kind = qtc_pkg::QTC_KIND_DATA;
            endcase
         end
      end
      // ----------------------------------------------------------------
      // self-test progress
      // ----------------------------------------------------------------
      with_sync = rx_common && enc_on;
      last_cnt = with_sync ? (qtc_pkg::BIST_CHARS + qtc_pkg::WS_CHARS - 10'h001)
                           : (qtc_pkg::BIST_CHARS - 10'h001);
      width = with_sync ? qtc_pkg::BIST_PULSE_SYNC : qtc_pkg::BIST_PULSE_PLAIN;
      wrap = bist_en && ref_tick && (st_q.bist_cnt >= last_cnt);
      if (!bist_en) begin
         st_d.bist_cnt = 10'h000;
         st_d.pulse_cnt = 5'h00;
      end else if (ref_tick) begin
         if (wrap) begin
            st_d.bist_cnt = 10'h000;
            st_d.pulse_cnt = width - 5'h01;
            st_d.bist_evt = 1'b1;
         end else begin
            st_d.bist_cnt = st_q.bist_cnt + 10'h001;
            if (st_q.pulse_cnt != 5'h00) begin
               st_d.pulse_cnt = st_q.pulse_cnt - 5'h01;
            end
         end
      end
      // ----------------------------------------------------------------
      // phase-align fault, set wins over clear
      // ----------------------------------------------------------------
      fault_set = pa_enable && pa_fault_event;
      fault_clr = realign_clear || (st_q.valid && st_q.kind == qtc_pkg::QTC_KIND_SYNC);
      st_d.fault = fault_set || (st_q.fault && !fault_clr);
      st_d.fault_evt = fault_set && !st_q.fault;
      // ----------------------------------------------------------------
      // parity pulse on capture ticks, error output moved only on reference ticks
      // ----------------------------------------------------------------
      st_d.par_evt = par_bad;
      if (ref_tick) begin
         st_d.par_pend = 1'b0;
         st_d.err = st_q.par_pend || par_bad || wrap || (bist_en && st_q.pulse_cnt != 5'h00) ||
            st_q.fault;
      end else begin
         st_d.par_pend = st_q.par_pend || par_bad;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign err_out = st_q.err;
   assign char_valid = st_q.valid;
   assign char_kind = st_q.kind;
   assign char_bits = st_q.bits;
   assign par_event = st_q.par_evt;
   assign fault_event = st_q.fault_evt;
   assign bist_event = st_q.bist_evt;

endmodule

// File: hw/qtc_pkg.sv
package qtc_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] MASK_OFF = 8'h08;
   localparam logic [7:0] STATE_OFF = 8'h0c;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_PAR_LSB = 2;
   localparam int CTRL_TXCK_LSB = 4;
   localparam int CTRL_HALF_BIT = 6;
   localparam int CTRL_RXCK_LSB = 7;
   localparam int CTRL_BIST_LSB = 12;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_f1ff;

   // ----------------------------------------------------------------
   // status / mask fields
   // ----------------------------------------------------------------
   localparam int STAT_PAR_LSB = 0;
   localparam int STAT_FAULT_LSB = 4;
   localparam int STAT_BIST_LSB = 8;
   localparam int STAT_W = 12;
   localparam logic [11:0] STATUS_RESET = 12'h000;
   localparam logic [11:0] MASK_RESET = 12'h000;

   // ----------------------------------------------------------------
   // three-level settings and character kinds
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      QTC_SEL_LOW = 2'b00,
      QTC_SEL_MID = 2'b01,
      QTC_SEL_HIGH = 2'b10
   } qtc_sel_e;

   typedef enum logic [2:0] {
      QTC_KIND_DATA = 3'b000,
      QTC_KIND_SPECIAL = 3'b001,
      QTC_KIND_FILL = 3'b010,
      QTC_KIND_SYNC = 3'b011,
      QTC_KIND_RAW = 3'b100
   } qtc_kind_e;

   // ----------------------------------------------------------------
   // character constants and self-test timing (character periods)
   // ----------------------------------------------------------------
   localparam logic [7:0] C07_BYTE = 8'he0;
   localparam logic [9:0] BIST_CHARS = 10'h1ff;
   localparam logic [9:0] WS_CHARS = 10'h010;
   localparam logic [4:0] BIST_PULSE_SYNC = 5'h11;
   localparam logic [4:0] BIST_PULSE_PLAIN = 5'h01;
   localparam logic [1:0] REALIGN_SAMPLES = 2'h2;

endpackage

// File: hw/qtc_sync.sv
`timescale 1ns/100ps
module qtc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // data
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } qtc_sync_s;

   qtc_sync_s st_q, st_d;

   initial begin
      if (W < 1) $error("qtc_sync width must be at least 1");
   end

   // first stage feeds only the second stage
   always_comb begin
      st_d = st_q;
      st_d.s1 = async_in;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_out = st_q.s2;

endmodule

// File: hw/qtc_top.sv
`timescale 1ns/100ps
module qtc_top #(
   parameter int CHANNELS = 4
) (
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // host character bus, asynchronous to pclk
   input wire logic reference_clock_in,
   input wire logic [3:0] tx_input_clock,
   input wire logic [7:0] tx_char_control,
   input wire logic [31:0] tx_char_byte,
   input wire logic [3:0] tx_odd_parity_in,
   input wire logic special_char_select,
   input wire logic tx_phase_realign_n,
   // phase-align buffer faults, pclk domain pulses
   input wire logic [3:0] pa_fault_event,
   // encoder side
   output logic [3:0] enc_char_valid,
   output logic [11:0] enc_char_kind,
   output logic [39:0] enc_char_bits,
   output logic pa_buffer_enable,
   // status
   output logic [3:0] tx_char_error_out,
   output logic irq
);

   localparam int AW = 51;

   typedef struct packed {
      logic [31:0] ctrl;
      logic [11:0] status;
      logic [11:0] mask;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic irq;
      logic ref_prev;
      logic [3:0] clk_prev;
      logic special_char_select_cap;
      logic [1:0] low_cnt;
      logic realign_clr;
      logic pa_en;
   } qtc_top_s;

   qtc_top_s st_q, st_d;

   initial begin
      if (CHANNELS != 4) $error("qtc_top serves exactly four channels");
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [AW-1:0] pins_s;
   logic ref_s;
   logic realign_n_s;
   logic special_char_select_s;
   logic [3:0] clk_s;
   logic [3:0] op_s;
   logic [7:0] ctl_s;
   logic [31:0] byte_s;

   qtc_sync #(
      .W(AW)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({tx_phase_realign_n, special_char_select, reference_clock_in, tx_input_clock,
                 tx_odd_parity_in, tx_char_control, tx_char_byte}),
      .sync_out(pins_s)
   );

   assign {realign_n_s, special_char_select_s, ref_s, clk_s, op_s, ctl_s, byte_s} = pins_s;

   // ----------------------------------------------------------------
   // configuration decode and clock edges
   // ----------------------------------------------------------------
   logic [1:0] enc_mode;
   logic [1:0] par_ctl;
   logic [1:0] txck_sel;
   logic half_rate;
   logic [1:0] rxck_sel;
   logic [3:0] bist_en;
   logic ref_rise;
   logic ref_fall;
   logic ref_tick;
   logic [3:0] clk_rise;
   logic [3:0] cap_tick;
   logic [3:0] special_char_select_ch;

   assign enc_mode = st_q.ctrl[qtc_pkg::CTRL_MODE_LSB +: 2];
   assign par_ctl = st_q.ctrl[qtc_pkg::CTRL_PAR_LSB +: 2];
   assign txck_sel = st_q.ctrl[qtc_pkg::CTRL_TXCK_LSB +: 2];
   assign half_rate = st_q.ctrl[qtc_pkg::CTRL_HALF_BIT];
   assign rxck_sel = st_q.ctrl[qtc_pkg::CTRL_RXCK_LSB +: 2];
   assign bist_en = st_q.ctrl[qtc_pkg::CTRL_BIST_LSB +: 4];

   assign ref_rise = ref_s && !st_q.ref_prev;
   assign ref_fall = !ref_s && st_q.ref_prev;
   assign ref_tick = ref_rise || (half_rate && ref_fall);
   assign clk_rise = clk_s & ~st_q.clk_prev;

   // ----------------------------------------------------------------
   // per-channel capture strobes and character checkers
   // ----------------------------------------------------------------
   logic [3:0] err_w;
   logic [3:0] par_evt_w;
   logic [3:0] fault_evt_w;
   logic [3:0] bist_evt_w;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_chan
         // reference source samples on every reference tick, input clocks on their rising edge
         assign cap_tick[g] = (txck_sel == qtc_pkg::QTC_SEL_LOW) ? ref_tick :
                              (txck_sel == qtc_pkg::QTC_SEL_MID) ? clk_rise[g] : clk_rise[0];
         assign special_char_select_ch[g] = (txck_sel == qtc_pkg::QTC_SEL_MID && g != 0) ? st_q.special_char_select_cap
                                                                             : special_char_select_s;

         qtc_chan u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .cap_tick(cap_tick[g]),
            .ref_tick(ref_tick),
            .tx_char_control(ctl_s[2*g +: 2]),
            .tx_char_byte(byte_s[8*g +: 8]),
            .tx_odd_parity_in(op_s[g]),
            .special_char_select(special_char_select_ch[g]),
            .tx_encode_mode(enc_mode),
            .parity_check_control(par_ctl),
            .rx_common(rxck_sel != qtc_pkg::QTC_SEL_MID),
            .bist_en(bist_en[g]),
            .pa_enable(st_q.pa_en),
            .realign_clear(st_q.realign_clr),
            .pa_fault_event(pa_fault_event[g]),
            .err_out(err_w[g]),
            .char_valid(enc_char_valid[g]),
            .char_kind(enc_char_kind[3*g +: 3]),
            .char_bits(enc_char_bits[10*g +: 10]),
            .par_event(par_evt_w[g]),
            .fault_event(fault_evt_w[g]),
            .bist_event(bist_evt_w[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // control, realign, interrupt and apb slave
   // ----------------------------------------------------------------
   logic setup;
   logic access;
   logic mapped;
   logic [11:0] set_bits;
   logic [11:0] clr_bits;

   always_comb begin
      st_d = st_q;
      st_d.ref_prev = ref_s;
      st_d.clk_prev = clk_s;
      if (clk_rise[0]) begin
         st_d.special_char_select_cap = special_char_select_s;
      end
      st_d.pa_en = (txck_sel != qtc_pkg::QTC_SEL_LOW) || half_rate;
      // realign needs two consecutive low samples at reference rising edges
      st_d.realign_clr = 1'b0;
      if (!st_q.pa_en) begin
         st_d.low_cnt = 2'h0;
      end else if (ref_rise) begin
         if (realign_n_s) begin
            st_d.low_cnt = 2'h0;
         end else if (st_q.low_cnt != qtc_pkg::REALIGN_SAMPLES) begin
            st_d.low_cnt = st_q.low_cnt + 2'h1;
            st_d.realign_clr = (st_q.low_cnt + 2'h1) == qtc_pkg::REALIGN_SAMPLES;
         end
      end
      // apb: registered answer, access phase of one cycle with no wait state
      setup = psel && !penable;
      access = psel && penable && st_q.ready;
      mapped = (paddr == qtc_pkg::CTRL_OFF) || (paddr == qtc_pkg::STATUS_OFF) ||
               (paddr == qtc_pkg::MASK_OFF) || (paddr == qtc_pkg::STATE_OFF);
      st_d.ready = setup;
      st_d.slverr = setup && !mapped;
      if (setup) begin
         case (paddr)
            qtc_pkg::CTRL_OFF: st_d.rdata = st_q.ctrl;
            qtc_pkg::STATUS_OFF: st_d.rdata = {20'h00000, st_q.status};
            qtc_pkg::MASK_OFF: st_d.rdata = {20'h00000, st_q.mask};
            qtc_pkg::STATE_OFF: st_d.rdata = {27'h0000000, st_q.pa_en, err_w};
            default: st_d.rdata = 32'h0000_0000;
         endcase
      end
      if (access && pwrite && paddr == qtc_pkg::CTRL_OFF) begin
         st_d.ctrl = pwdata & qtc_pkg::CTRL_WMASK;
      end
      if (access && pwrite && paddr == qtc_pkg::MASK_OFF) begin
         st_d.mask = pwdata[11:0];
      end
      // a read clears what it returned; a new event in the same cycle survives
      clr_bits = (access && !pwrite && paddr == qtc_pkg::STATUS_OFF) ? st_q.rdata[11:0] : 12'h000;
      set_bits = {bist_evt_w, fault_evt_w, par_evt_w};
      st_d.status = (st_q.status & ~clr_bits) | set_bits;
      st_d.irq = |(st_d.status & st_d.mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
         st_q.ctrl <= qtc_pkg::CTRL_RESET;
         st_q.status <= qtc_pkg::STATUS_RESET;
         st_q.mask <= qtc_pkg::MASK_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata = st_q.rdata;
   assign pready = st_q.ready;
   assign pslverr = st_q.slverr;
   assign irq = st_q.irq;
   assign pa_buffer_enable = st_q.pa_en;
   assign tx_char_error_out = err_w;

endmodule

// File: testbench/qtc_host_model.sv
`timescale 1ns/100ps
module qtc_host_model (
   // bench control
   input wire logic [1:0] ctl,
   input wire logic [7:0] base,
   input wire logic [3:0] bad,
   input wire logic shot,
   input wire logic sel,
   input wire logic realign,
   // host character bus
   output logic reference_clock_in,
   output logic [3:0] tx_input_clock,
   output logic [7:0] tx_char_control,
   output logic [31:0] tx_char_byte,
   output logic [3:0] tx_odd_parity_in,
   output logic special_char_select,
   output logic tx_phase_realign_n
);
   logic done, one;
   logic [7:0] b;
   initial begin
      reference_clock_in = 1'b0;
      done = 1'b0;
      tx_char_control = 8'h00;
      tx_char_byte = 32'h0;
      tx_odd_parity_in = 4'hf;
      special_char_select = 1'b0;
      tx_phase_realign_n = 1'b1;
      #13;
      forever #40 reference_clock_in = ~reference_clock_in;
   end
   assign tx_input_clock = {4{reference_clock_in}};
   // launch on the falling edge for setup and hold margin
   always @(negedge reference_clock_in) begin
      one = shot && !done;
      done = shot;
      special_char_select = sel;
      tx_phase_realign_n = !realign;
      for (int g = 0; g < 4; g++) begin
         b = base + 8'(g);
         tx_char_control[2*g +: 2] = ctl;
         tx_char_byte[8*g +: 8] = b;
         tx_odd_parity_in[g] = ~^{ctl, b} ^ (one & bad[g]);
      end
   end
endmodule

// File: testbench/qtc_top_properties.sv
`timescale 1ns/100ps
module qtc_top_properties (
   // apb side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // link and status side
   input wire logic reference_clock_in,
   input wire logic [3:0] pa_fault_event,
   input wire logic [3:0] enc_char_valid,
   input wire logic [11:0] enc_char_kind,
   input wire logic pa_buffer_enable,
   input wire logic [3:0] tx_char_error_out,
   input wire logic irq
);
   // ------
   // shadow state
   // ------
   logic [31:0] ctrl_q;
   logic [11:0] mask_q;
   logic [5:0] age_q;
   logic [3:0] since_q;
   logic ref_q, wr_ok;
   assign wr_ok = psel && penable && pready && pwrite;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 32'h0;
         mask_q <= 12'h0;
         age_q <= 6'h0;
         ref_q <= 1'b0;
         since_q <= 4'hf;
      end else begin
         ref_q <= reference_clock_in;
         since_q <= (reference_clock_in != ref_q) ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
         age_q <= age_q + {5'h0, age_q != 6'h3f};
         if (wr_ok && paddr == qtc_pkg::CTRL_OFF) begin
            ctrl_q <= pwdata;
            age_q <= 6'h0;
         end
         if (wr_ok && paddr == qtc_pkg::MASK_OFF) begin
            mask_q <= pwdata[11:0];
            age_q <= 6'h0;
         end
      end
   end
   // ------
   // properties
   // ------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready_next; psel && !penable |=> pready; endproperty
   a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
   property p_ready_one; pready |=> !pready; endproperty
   a_ready_one: assert property (p_ready_one) else $error("ready longer than one cycle");
   property p_unmapped; psel && !penable && paddr > 8'h0c |=> pslverr; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access without error");
   property p_valid_one; enc_char_valid[0] |=> !enc_char_valid[0]; endproperty
   a_valid_one: assert property (p_valid_one) else $error("character strobe too long");
   property p_raw_kind; enc_char_valid[0] && age_q > 6'd40 && ctrl_q[1:0] == 2'b00
      |-> enc_char_kind[2:0] inside {qtc_pkg::QTC_KIND_RAW, qtc_pkg::QTC_KIND_SPECIAL}; endproperty
   a_raw_kind: assert property (p_raw_kind) else $error("bypass char not raw");
   property p_enc_kind; enc_char_valid[1] && age_q > 6'd40 && ctrl_q[1:0] != 2'b00
      |-> enc_char_kind[5:3] != qtc_pkg::QTC_KIND_RAW; endproperty
   a_enc_kind: assert property (p_enc_kind) else $error("encoded char sent raw");
   property p_pa_en; age_q > 6'd3 |-> pa_buffer_enable == (ctrl_q[5:4] != 2'b00 || ctrl_q[6]); endproperty
   a_pa_en: assert property (p_pa_en) else $error("phase buffer enable wrong");
   property p_err_edge; $changed(tx_char_error_out) |-> since_q < 4'h6; endproperty
   a_err_edge: assert property (p_err_edge) else $error("error output off reference edge");
   property p_fault; pa_fault_event[1] && pa_buffer_enable |-> ##[1:30] tx_char_error_out[1]; endproperty
   a_fault: assert property (p_fault) else $error("buffer fault not reported");
   property p_irq_off; mask_q == 12'h0 && age_q > 6'd3 |-> !irq; endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt with all masked");
endmodule

bind qtc_top qtc_top_properties u_props (.*);

// File: testbench/quad_tx_char_input_check_test.sv
`timescale 1ns/100ps
module quad_tx_char_input_check_test;
   // ------
   // signals
   // ------
   localparam int REF_PCLK = 10;
   // fields: mode, control, select, kind
   localparam logic [7:0] ENC_TAB [7] = '{8'h80, 8'hb3, 8'h71, 8'h7b, 8'h91, 8'h62, 8'h48};
   localparam logic [7:0] PA_TAB [4] = '{8'h00, 8'h40, 8'h10, 8'h20};
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic shot = 1'b0, sel = 1'b0, realign = 1'b0;
   logic [7:0] paddr = 8'h00, base = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pa_fault_event = 4'h0, bad = 4'h0;
   logic [1:0] ctl = 2'b00;
   logic pready, pslverr, reference_clock_in, special_char_select, tx_phase_realign_n, pa_buffer_enable, irq;
   logic [3:0] tx_input_clock, tx_odd_parity_in, enc_char_valid, err;
   logic [31:0] prdata, tx_char_byte;
   logic [7:0] tx_char_control;
   logic [11:0] enc_char_kind;
   logic [39:0] enc_char_bits;
   int fail_count = 0, comparisons = 0;
   always #4 pclk = ~pclk;
   qtc_host_model u_host (.*);
   qtc_top u_dut (.*, .tx_char_error_out(err));
   // ------
   // shared tasks
   // ------
   task automatic finish_test();
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      if (a > 8'h0c) chk({31'h0, pslverr}, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk(32'h0, 32'h1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask
   task automatic next_char(input int ch, output logic [2:0] k, output logic [9:0] b);
      int n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (enc_char_valid[ch] !== 1'b1 && n < 60);
      k = enc_char_kind[3*ch +: 3];
      b = enc_char_bits[10*ch +: 10];
      if (n >= 60) chk(32'h0, 32'h1);
   endtask
   task automatic settle(input int ch, output logic [2:0] k, output logic [9:0] b);
      repeat (3) next_char(ch, k, b);
   endtask
   task automatic err_width(input int lim, output int w);
      int n = 0;
      w = 0;
      while (err[0] !== 1'b1 && n < lim) begin
         @(negedge pclk);
         n++;
      end
      chk({28'h0, err}, 32'h1);
      while (err[0] === 1'b1 && w < 400) begin
         @(negedge pclk);
         w++;
      end
   endtask
   task automatic pulse_fault();
      repeat (4) @(posedge pclk);
      pa_fault_event <= 4'h2;
      @(posedge pclk);
      pa_fault_event <= 4'h0;
   endtask
   // ------
   // scenarios
   // ------
   task automatic t_regs();
      rd(qtc_pkg::CTRL_OFF, qtc_pkg::CTRL_RESET);
      rd(qtc_pkg::STATUS_OFF, {20'h0, qtc_pkg::STATUS_RESET});
      rd(qtc_pkg::MASK_OFF, {20'h0, qtc_pkg::MASK_RESET});
      rd(8'h10, 32'h0);
      wr(qtc_pkg::CTRL_OFF, 32'hffff_ffff);
      rd(qtc_pkg::CTRL_OFF, qtc_pkg::CTRL_WMASK);
      wr(qtc_pkg::CTRL_OFF, 32'h0);
   endtask
   task automatic t_pa();
      for (int i = 0; i < 4; i++) begin
         wr(qtc_pkg::CTRL_OFF, {24'h0, PA_TAB[i]});
         rd(qtc_pkg::STATE_OFF, (i == 0) ? 32'h0 : 32'h10);
      end
   endtask
   task automatic t_bypass();
      logic [2:0] k;
      logic [9:0] b;
      wr(qtc_pkg::CTRL_OFF, 32'h8);
      ctl <= 2'b10;
      base <= 8'h5a;
      for (int g = 0; g < 4; g++) begin
         settle(g, k, b);
         chk({29'h0, k}, {29'h0, qtc_pkg::QTC_KIND_RAW});
         chk({22'h0, b}, {22'h0, 2'b10, 8'h5a + 8'(g)});
      end
   endtask
   task automatic t_parity(input logic [1:0] mode);
      logic [2:0] k;
      logic [9:0] b;
      int n = 0;
      int w;
      rd(qtc_pkg::STATUS_OFF, 32'h0);
      wr(qtc_pkg::CTRL_OFF, {28'h0, 2'b10, mode});
      wr(qtc_pkg::MASK_OFF, 32'h1);
      ctl <= (mode == 2'b00) ? 2'b01 : 2'b00;
      base <= 8'h21;
      bad <= 4'h1;
      settle(0, k, b);
      shot <= 1'b1;
      do begin
         next_char(0, k, b);
         n++;
      end while (k !== qtc_pkg::QTC_KIND_SPECIAL && n < 8);
      chk({22'h0, b}, {22'h0, 2'b00, qtc_pkg::C07_BYTE});
      err_width(30, w);
      chk(32'(w >= REF_PCLK - 2 && w <= REF_PCLK + 2), 32'h1);
      chk({31'h0, irq}, 32'h1);
      rd(qtc_pkg::STATUS_OFF, 32'h1);
      repeat (2) @(negedge pclk);
      chk({31'h0, irq}, 32'h0);
      shot <= 1'b0;
   endtask
   task automatic t_encode();
      logic [2:0] k;
      logic [9:0] b;
      base <= 8'h3c;
      for (int i = 0; i < 7; i++) begin
         wr(qtc_pkg::CTRL_OFF, {30'h0, ENC_TAB[i][7:6]});
         ctl <= ENC_TAB[i][5:4];
         sel <= ENC_TAB[i][3];
         settle(1, k, b);
         chk({29'h0, k}, {29'h0, ENC_TAB[i][2:0]});
         if (ENC_TAB[i][2:0] == 3'h0) chk({22'h0, b}, 32'h3d);
      end
   endtask
   task automatic t_fault();
      wr(qtc_pkg::CTRL_OFF, 32'h0);
      pulse_fault();
      repeat (30) @(negedge pclk);
      chk({28'h0, err}, 32'h0);
      wr(qtc_pkg::CTRL_OFF, 32'h12);
      for (int i = 0; i < 2; i++) begin
         pulse_fault();
         repeat (150) @(posedge pclk);
         chk({28'h0, err}, 32'h2);
         if (i == 0) realign <= 1'b1;
         else ctl <= 2'b11;
         repeat (60) @(posedge pclk);
         realign <= 1'b0;
         ctl <= 2'b00;
         repeat (40) @(posedge pclk);
         chk({28'h0, err}, 32'h0);
      end
      rd(qtc_pkg::STATUS_OFF, 32'h20);
   endtask
   task automatic t_bist(input logic [1:0] rx, input int per);
      int w;
      wr(qtc_pkg::CTRL_OFF, {16'h0, 4'h1, 3'h0, rx, 7'h02});
      err_width(6000, w);
      chk(32'(w >= per * REF_PCLK - 2 && w <= per * REF_PCLK + 2), 32'h1);
      rd(qtc_pkg::STATUS_OFF, 32'h100);
      wr(qtc_pkg::CTRL_OFF, 32'h0);
   endtask
   // ------
   // sequence and watchdog
   // ------
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_pa();
      t_bypass();
      t_parity(2'b00);
      t_parity(2'b10);
      t_encode();
      t_fault();
      t_bist(2'b01, 1);
      t_bist(2'b00, 17);
      finish_test();
   end
   initial begin
      #(8 * 40000);
      fail_count++;
      finish_test();
   end
endmodule
